// >>> hw/link_regs_pkg.sv
package link_regs_pkg;

  // register byte offsets
  localparam logic [7:0] LINK_CTRL_STAT_OFS = 8'hd0;  // control low half, status high half
  localparam logic [7:0] INT_STATUS_OFS     = 8'he0;
  localparam logic [7:0] INT_MASK_OFS       = 8'he4;

  // control field positions
  localparam int ASPM_LSB    = 0;
  localparam int RD_BOUNDARY_BIT = 3;
  localparam int LDIS_BIT    = 4;
  localparam int RETRAIN_BIT = 5;
  localparam int CCLK_BIT    = 6;
  localparam int EXTS_BIT    = 7;
  localparam int HWAW_BIT    = 9;
  localparam int C10_BIT     = 10;
  localparam int C11_BIT     = 11;

  // status field positions within the shared word
  localparam int SPEED_LSB   = 16;
  localparam int WIDTH_LSB   = 20;
  localparam int TERR_BIT    = 26;
  localparam int TRAIN_BIT   = 27;
  localparam int SLOT_CLOCK_BIT = 28;
  localparam int DLACT_BIT   = 29;

  // speed codes and reset values
  localparam logic [3:0] SPEED_2G5   = 4'h1;
  localparam logic [3:0] SPEED_5G0   = 4'h2;
  localparam logic [3:0] SPEED_RESET = 4'h2;

  // extended synch ordered-set counts
  localparam logic [12:0] EXT_FTS_COUNT = 13'h1000;  // 4096
  localparam logic [12:0] EXT_TS1_COUNT = 13'h0400;  // 1024

  // interrupt event bits
  localparam int INT_W        = 3;
  localparam int EV_TRAIN_ERR = 0;
  localparam int EV_TRAIN_END = 1;
  localparam int EV_DL_CHANGE = 2;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // control register contents
  typedef struct packed {
    logic       ctrl11;
    logic       ctrl10;
    logic       hw_width_disable;
    logic       ext_synch;
    logic       common_clock;
    logic       link_disable;
    logic [1:0] aspm;
  } link_ctrl_t;

  // reports from training and data link logic
  typedef struct packed {
    logic       train_start;  // pulse
    logic       train_done;   // pulse, reached L0
    logic       train_fail;   // pulse
    logic       neg_valid;    // pulse, speed and width below are valid
    logic [3:0] neg_speed;
    logic [5:0] neg_width;
    logic       dl_active;    // level
  } link_report_t;

endpackage

// >>> hw/pcie_port_link_ctrl_status.sv
`timescale 1ns/1ps
module pcie_port_link_ctrl_status
  import link_regs_pkg::*;
#(
  parameter bit          UPSTREAM    = 1'b0,
  parameter logic [5:0]  WIDTH_RESET = 6'h01,
  parameter logic [12:0] NORM_FTS    = 13'h0080,
  parameter logic [12:0] NORM_TS1    = 13'h0010,
  parameter int          ADDR_W      = 8
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic                ce,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0]   awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0]   araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  // training and data link reports
  input  wire link_regs_pkg::link_report_t report,
  // slot clock strap and override load
  input  wire logic                slot_clock_strap,
  input  wire logic                slot_clock_load,
  input  wire logic                slot_clock_value,
  // controls toward the link
  output link_regs_pkg::link_ctrl_t link_control,
  output logic                     retrain,
  output logic                     rx_l0s_allowed,
  output logic [12:0]              fts_count,
  output logic [12:0]              ts1_count,
  // interrupt
  output logic                     irq
);

  // refuse settings the logic cannot serve
  generate
    if (ADDR_W < 8 || NORM_FTS > EXT_FTS_COUNT || NORM_TS1 > EXT_TS1_COUNT) begin : g_bad
      $error("pcie_port_link_ctrl_status: bad parameter");
    end
  endgenerate

  logic [ADDR_W-1:0] aw_addr;
  logic              aw_full;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              w_full;
  logic              next_aw_full;
  logic              next_w_full;
  logic              next_bvalid;
  logic              next_rvalid;
  logic              do_write;
  logic              ar_hs;
  logic [3:0]        speed;
  logic [5:0]        width;
  logic              train_err;
  logic              training;
  logic              slot_clk;
  logic              strap_taken;
  logic              dl_active;
  logic [INT_W-1:0]  int_status;
  logic [INT_W-1:0]  int_mask;
  logic [INT_W-1:0]  next_int_status;
  logic [INT_W-1:0]  next_int_mask;
  logic [INT_W-1:0]  int_set;

  // word-aligned address match
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(ofs[7:2]));
  endfunction

  // read value of an address; reserved and write-only bits are zero
  function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (hit(a, LINK_CTRL_STAT_OFS)) begin
      v[ASPM_LSB +: 2]        = link_control.aspm;
      v[RD_BOUNDARY_BIT]      = 1'b0;
      v[LDIS_BIT]             = link_control.link_disable;
      v[RETRAIN_BIT]          = 1'b0;
      v[CCLK_BIT]             = link_control.common_clock;
      v[EXTS_BIT]             = link_control.ext_synch;
      v[HWAW_BIT]             = link_control.hw_width_disable;
      v[C10_BIT]              = link_control.ctrl10;
      v[C11_BIT]              = link_control.ctrl11;
      v[SPEED_LSB +: 4]       = speed;
      v[WIDTH_LSB +: 6]       = width;
      v[TERR_BIT]             = train_err;
      v[TRAIN_BIT]            = training;
      v[SLOT_CLOCK_BIT]       = slot_clk;
      v[DLACT_BIT]            = dl_active;
    end else if (hit(a, INT_STATUS_OFS)) begin
      v[INT_W-1:0] = int_status;
    end else if (hit(a, INT_MASK_OFS)) begin
      v[INT_W-1:0] = int_mask;
    end
    read_word = v;
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, LINK_CTRL_STAT_OFS) | hit(a, INT_STATUS_OFS) | hit(a, INT_MASK_OFS);
  endfunction

  // write channel bookkeeping
  assign do_write     = aw_full & w_full & ~bvalid;
  assign next_aw_full = do_write ? 1'b0 : (aw_full | (awvalid & awready));
  assign next_w_full  = do_write ? 1'b0 : (w_full | (wvalid & wready));
  assign next_bvalid  = do_write | (bvalid & ~bready);

  // address and data taken in either order, answered once both are held
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      aw_addr <= '0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_data <= wdata;
        w_strb <= wstrb;
      end
      aw_full <= next_aw_full;
      w_full  <= next_w_full;
      awready <= ~next_aw_full & ~next_bvalid;
      wready  <= ~next_w_full & ~next_bvalid;
      bvalid  <= next_bvalid;
      if (do_write) begin
        bresp <= mapped(aw_addr) ? RESP_OKAY : RESP_DECERR;
      end
    end
  end

  // read channel: data one cycle after the address is taken
  assign ar_hs       = arvalid & arready;
  assign next_rvalid = ar_hs | (rvalid & ~rready);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (ce) begin
      arready <= ~next_rvalid;
      rvalid  <= next_rvalid;
      if (ar_hs) begin
        rdata <= read_word(araddr);
        rresp <= mapped(araddr) ? RESP_OKAY : RESP_DECERR;
      end
    end
  end

  // control register; reserved bits are never stored
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      link_control <= '0;
    end else if (ce && do_write && hit(aw_addr, LINK_CTRL_STAT_OFS)) begin
      if (w_strb[0]) begin
        link_control.aspm         <= w_data[ASPM_LSB +: 2];
        link_control.common_clock <= w_data[CCLK_BIT];
        link_control.ext_synch    <= w_data[EXTS_BIT];
        link_control.link_disable <= ~UPSTREAM & w_data[LDIS_BIT];
      end
      if (w_strb[1]) begin
        link_control.hw_width_disable <= w_data[HWAW_BIT];
        link_control.ctrl10           <= ~UPSTREAM & w_data[C10_BIT];
        link_control.ctrl11           <= ~UPSTREAM & w_data[C11_BIT];
      end
    end
  end

  // retrain pulse and ordered-set counts toward the link
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      retrain        <= 1'b0;
      rx_l0s_allowed <= 1'b0;
      fts_count      <= NORM_FTS;
      ts1_count      <= NORM_TS1;
    end else if (ce) begin
      retrain <= ~UPSTREAM & do_write & hit(aw_addr, LINK_CTRL_STAT_OFS)
                 & w_strb[0] & w_data[RETRAIN_BIT];
      rx_l0s_allowed <= 1'b1;
      fts_count <= link_control.ext_synch ? EXT_FTS_COUNT : NORM_FTS;
      ts1_count <= link_control.ext_synch ? EXT_TS1_COUNT : NORM_TS1;
    end
  end

  // link status: speed, width, training flags, data link state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      speed     <= SPEED_RESET;
      width     <= WIDTH_RESET;
      train_err <= 1'b0;
      training  <= 1'b1;
      dl_active <= 1'b0;
    end else if (ce) begin
      if (report.neg_valid) begin
        if (report.neg_speed == SPEED_2G5 || report.neg_speed == SPEED_5G0) begin
          speed <= report.neg_speed;
        end
        width <= report.neg_width;
      end
      if (report.train_fail) begin
        train_err <= 1'b1;
      end else if (report.train_done) begin
        train_err <= 1'b0;
      end
      if (report.train_start || retrain) begin
        training <= 1'b1;
      end else if (report.train_done || report.train_fail) begin
        training <= 1'b0;
      end
      dl_active <= report.dl_active;
    end
  end

  // slot clock taken from the strap after reset release, then loadable
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slot_clk    <= 1'b0;
      strap_taken <= 1'b0;
    end else if (ce) begin
      strap_taken <= 1'b1;
      if (!strap_taken) begin
        slot_clk <= slot_clock_strap;
      end else if (slot_clock_load) begin
        slot_clk <= slot_clock_value;
      end
    end
  end

  // interrupt events, write-one-to-clear, set wins over clear
  always_comb begin
    int_set               = '0;
    int_set[EV_TRAIN_ERR] = report.train_fail;
    int_set[EV_TRAIN_END] = report.train_done;
    int_set[EV_DL_CHANGE] = report.dl_active ^ dl_active;
    next_int_status = int_status;
    next_int_mask   = int_mask;
    if (do_write && w_strb[0] && hit(aw_addr, INT_STATUS_OFS)) begin
      next_int_status = int_status & ~w_data[INT_W-1:0];
    end
    if (do_write && w_strb[0] && hit(aw_addr, INT_MASK_OFS)) begin
      next_int_mask = w_data[INT_W-1:0];
    end
    next_int_status = next_int_status | int_set;
  end

  // status, mask and the level interrupt move together
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      int_status <= '0;
      int_mask   <= '0;
      irq        <= 1'b0;
    end else if (ce) begin
      int_status <= next_int_status;
      int_mask   <= next_int_mask;
      irq        <= |(next_int_status & next_int_mask);
    end
  end

  // assertions
  sequence s_ctrl_write;
    ce && do_write && hit(aw_addr, LINK_CTRL_STAT_OFS) && w_strb[0];
  endsequence

  sequence s_ctrl_read;
    ce && ar_hs && hit(araddr, LINK_CTRL_STAT_OFS);
  endsequence

  a_aspm_write: assert property (@(posedge clk) disable iff (!rstn)
    s_ctrl_write |=> link_control.aspm == $past(w_data[1:0]))
    else $error("aspm field did not take written value");

  a_l0s_allowed: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) && $past(ce) |-> rx_l0s_allowed)
    else $error("receiver L0s entry blocked");

  a_rsvd_reads: assert property (@(posedge clk) disable iff (!rstn)
    s_ctrl_read |=> rvalid && rdata[RD_BOUNDARY_BIT] == 1'b0 && rdata[RETRAIN_BIT] == 1'b0
      && rdata[2] == 1'b0 && rdata[31:30] == 2'h0)
    else $error("reserved or boundary bit read nonzero");

  a_upstream_hw0: assert property (@(posedge clk) disable iff (!rstn)
    UPSTREAM |-> !link_control.link_disable && !link_control.ctrl10 && !link_control.ctrl11
      && !retrain)
    else $error("upstream hardwired bit set");

  a_retrain_pulse: assert property (@(posedge clk) disable iff (!rstn)
    s_ctrl_write ##0 w_data[RETRAIN_BIT] |=> retrain == !UPSTREAM ##1 (training || !ce))
    else $error("retrain not started by write");

  a_ext_synch: assert property (@(posedge clk) disable iff (!rstn)
    ce && link_control.ext_synch |=> fts_count == EXT_FTS_COUNT && ts1_count == EXT_TS1_COUNT)
    else $error("extended synch counts wrong");

  a_speed_hold: assert property (@(posedge clk) disable iff (!rstn)
    ##1 (speed == SPEED_2G5 || speed == SPEED_5G0))
    else $error("illegal speed code");

  a_train_err: assert property (@(posedge clk) disable iff (!rstn)
    ce && report.train_fail |=> train_err ##0 !training)
    else $error("training error not flagged");

  a_train_done: assert property (@(posedge clk) disable iff (!rstn)
    ce && report.train_done && !report.train_fail && !report.train_start && !retrain
      |=> !training && !train_err)
    else $error("training flags not cleared at L0");

  a_dl_active: assert property (@(posedge clk) disable iff (!rstn)
    ce |=> dl_active == $past(report.dl_active))
    else $error("data link active not tracking");

  a_irq_level: assert property (@(posedge clk) disable iff (!rstn)
    irq == |(int_status & int_mask))
    else $error("interrupt level inconsistent");

  a_common_clock: assert property (@(posedge clk) disable iff (!rstn)
    s_ctrl_write |=> link_control.common_clock == $past(w_data[CCLK_BIT]))
    else $error("common clock bit did not take written value");

  a_width_change: assert property (@(posedge clk) disable iff (!rstn)
    ce && do_write && hit(aw_addr, LINK_CTRL_STAT_OFS) && w_strb[1]
      |=> link_control.hw_width_disable == $past(w_data[HWAW_BIT]))
    else $error("width change disable bit did not take written value");

  a_width_load: assert property (@(posedge clk) disable iff (!rstn)
    ce && report.neg_valid |=> width == $past(report.neg_width))
    else $error("negotiated width not loaded");

  a_slot_load: assert property (@(posedge clk) disable iff (!rstn)
    ce && strap_taken && slot_clock_load |=> slot_clk == $past(slot_clock_value))
    else $error("slot clock override not loaded");

  a_ce_freeze: assert property (@(posedge clk) disable iff (!rstn)
    !ce |=> $stable(link_control) && $stable(slot_clk) && $stable(training))
    else $error("state changed while clock enable low");

endmodule

// >>> verif/link_partner_model.sv
`timescale 1ns/1ps
module link_partner_model
  import link_regs_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rstn,
  // controls from the port
  input  wire logic                   retrain,
  input  wire logic                   link_disable,
  // behaviour chosen by the bench
  input  wire logic                   fail_next,
  input  wire logic [3:0]             lat,
  input  wire logic [3:0]             speed,
  input  wire logic [5:0]             width,
  // reports toward the port
  output link_regs_pkg::link_report_t report
);
  logic       busy;
  logic [3:0] cnt;
  logic       fin;

  // training ends when the latency count runs out
  assign fin = busy && cnt == 4'h0;

  // training runs lat+1 cycles after a retrain pulse, then succeeds or fails
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy   <= 1'b0;
      cnt    <= 4'h0;
      report <= '0;
    end else begin
      report.train_start <= retrain;
      report.train_done  <= fin && !fail_next;
      report.train_fail  <= fin && fail_next;
      report.neg_valid   <= fin && !fail_next;
      // outside a valid pulse the fields carry a changing pattern
      report.neg_speed   <= (fin && !fail_next) ? speed : ~report.neg_speed;
      report.neg_width   <= (fin && !fail_next) ? width : ~report.neg_width;
      if (link_disable) begin
        report.dl_active <= 1'b0;
      end else if (fin) begin
        report.dl_active <= !fail_next;
      end
      if (retrain) begin
        busy <= 1'b1;
        cnt  <= lat;
      end else if (busy) begin
        busy <= !fin;
        cnt  <= cnt - 4'h1;
      end
    end
  end
endmodule

// >>> verif/test_pcie_port_link_ctrl_status.sv
`timescale 1ns/1ps
module test_pcie_port_link_ctrl_status;
  import link_regs_pkg::*;
  localparam logic [5:0]  WRST = 6'h04;
  localparam logic [12:0] NFTS = 13'h0080;
  localparam logic [12:0] NTS1 = 13'h0010;
  logic         clk, rstn, ce, strap, sc_load, sc_val, fail_next;
  logic [7:0]   awaddr, araddr;
  logic         awvalid, awready, wvalid, wready, bvalid, bready;
  logic         arvalid, arready, rvalid, rready, retrain, rx_l0s, irq;
  logic [31:0]  wdata, rdata, d;
  logic [3:0]   wstrb, lat;
  logic [1:0]   bresp, rresp, r;
  logic [12:0]  fts, ts1;
  link_report_t report;
  link_ctrl_t   lctl;
  int           errors, n_compared, n_retrain;

  pcie_port_link_ctrl_status #(.WIDTH_RESET(WRST), .NORM_FTS(NFTS), .NORM_TS1(NTS1))
    pcie_port_link_ctrl_status_i (
    .clk(clk), .rstn(rstn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .report(report), .slot_clock_strap(strap), .slot_clock_load(sc_load),
    .slot_clock_value(sc_val), .link_control(lctl), .retrain(retrain),
    .rx_l0s_allowed(rx_l0s), .fts_count(fts), .ts1_count(ts1), .irq(irq));

  link_partner_model link_partner_model_i (
    .clk(clk), .rstn(rstn), .retrain(retrain), .link_disable(lctl.link_disable),
    .fail_next(fail_next), .lat(lat), .speed(4'h1), .width(6'h02), .report(report));

  // clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // count retrain pulses seen at the port
  always @(posedge clk) begin
    if (retrain === 1'b1) begin
      n_retrain++;
    end
  end

  // upper half of the shared word
  function automatic logic [15:0] stat(logic dl, logic sc, logic tr, logic te, logic [5:0] w,
                                       logic [3:0] s);
    return {2'b00, dl, sc, tr, te, w, s};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic timed_out();
    errors++;
    $display("mismatch at %0t: bus wait ran out", $time);
    stop_test();
  endtask

  // one write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge clk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1) begin
        resp = bresp;
        bready <= 1'b0;
        return;
      end
    end
    timed_out();
  endtask

  // one read
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge clk);
      if (arready === 1'b1) begin
        arvalid <= 1'b0;
      end
      if (rvalid === 1'b1) begin
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
        return;
      end
    end
    timed_out();
  endtask

  // main sequence
  initial begin
    {rstn, awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
    {wdata, wstrb, sc_load, sc_val, fail_next} = '0;
    ce = 1'b1;
    strap = 1'b1;
    lat = 4'hc;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    // reset contents
    rd(LINK_CTRL_STAT_OFS, d, r);
    check(32'(d[31:16]), 32'(stat(0, 1, 1, 0, WRST, 4'h2)), "reset status");
    check(32'(d[15:0]), 32'h0000_0000, "reset control");
    check(32'(r), 32'(RESP_OKAY), "mapped read response");
    check(32'(fts), 32'(NFTS), "normal fts");
    // every power-state code, reserved and boundary bits written as ones
    for (int i = 0; i < 4; i++) begin
      wr(LINK_CTRL_STAT_OFS, 32'h0000_f10c | 32'(i), r);
      rd(LINK_CTRL_STAT_OFS, d, r);
      check(32'(d[15:0]), 32'(i), "aspm readback");
      check(32'(lctl.aspm), 32'(i), "aspm out");
      check(32'(rx_l0s), 32'h0000_0001, "rx l0s");
    end
    // all writable control bits except retrain
    wr(LINK_CTRL_STAT_OFS, 32'hffff_ffdf, r);
    rd(LINK_CTRL_STAT_OFS, d, r);
    check(d, {stat(0, 1, 1, 0, WRST, 4'h2), 16'h0ed3}, "rw bits");
    check(32'(lctl), 32'h0000_00ff, "control out");
    check({fts, 6'h00, ts1}, {13'h1000, 6'h00, 13'h0400}, "extended synch");
    wr(LINK_CTRL_STAT_OFS, 32'h0000_0000, r);
    rd(LINK_CTRL_STAT_OFS, d, r);
    check({fts, 6'h00, ts1}, {NFTS, 6'h00, NTS1}, "normal synch");
    // slow retrain
    wr(LINK_CTRL_STAT_OFS, 32'h0000_0020, r);
    rd(LINK_CTRL_STAT_OFS, d, r);
    check(32'(d[15:0]), 32'h0000_0000, "retrain reads zero");
    check(32'(d[27]), 32'h0000_0001, "training");
    check(32'(n_retrain), 32'h0000_0001, "retrain pulse");
    repeat (20) @(posedge clk);
    rd(LINK_CTRL_STAT_OFS, d, r);
    check(32'(d[31:16]), 32'(stat(1, 1, 0, 0, 6'h02, 4'h1)), "trained");
    rd(INT_STATUS_OFS, d, r);
    check(d, 32'h0000_0006, "events");
    // interrupt masked, unmasked and cleared
    wr(INT_MASK_OFS, 32'h0000_0007, r);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h0000_0001, "irq set");
    wr(INT_MASK_OFS, 32'h0000_0000, r);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h0000_0000, "irq masked");
    wr(INT_MASK_OFS, 32'h0000_0007, r);
    wr(INT_STATUS_OFS, 32'h0000_0006, r);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h0000_0000, "irq cleared");
    // prompt failing retrain, then a good one
    fail_next <= 1'b1;
    lat <= 4'h1;
    wr(LINK_CTRL_STAT_OFS, 32'h0000_0020, r);
    repeat (10) @(posedge clk);
    rd(LINK_CTRL_STAT_OFS, d, r);
    check(32'(d[31:16]), 32'(stat(0, 1, 0, 1, 6'h02, 4'h1)), "train fail");
    check(32'(irq), 32'h0000_0001, "irq on fail");
    fail_next <= 1'b0;
    wr(LINK_CTRL_STAT_OFS, 32'h0000_0020, r);
    repeat (10) @(posedge clk);
    rd(LINK_CTRL_STAT_OFS, d, r);
    check(32'(d[31:16]), 32'(stat(1, 1, 0, 0, 6'h02, 4'h1)), "error cleared");
    check(32'(n_retrain), 32'h0000_0003, "retrain count");
    // slot clock override
    sc_load <= 1'b1;
    @(posedge clk);
    sc_load <= 1'b0;
    repeat (2) @(posedge clk);
    rd(LINK_CTRL_STAT_OFS, d, r);
    check(32'(d[28]), 32'h0000_0000, "slot clock load");
    // clock enable low freezes the slot clock bit against a load
    ce <= 1'b0;
    sc_val <= 1'b1;
    sc_load <= 1'b1;
    @(posedge clk);
    sc_load <= 1'b0;
    ce <= 1'b1;
    rd(LINK_CTRL_STAT_OFS, d, r);
    check(32'(d[28]), 32'h0000_0000, "slot clock frozen");
    // unmapped address
    wr(8'hf0, 32'hffff_ffff, r);
    check(32'(r), 32'(RESP_DECERR), "unmapped write");
    rd(8'hf0, d, r);
    check({d[29:0], r}, 32'(RESP_DECERR), "unmapped read");
    stop_test();
  end
endmodule
